//--- core/tfd_pkg.sv
/*
  Constants, field positions and format codes for the texel format decoder.
  Assumes the fetch side packs words little-endian, byte 0 in bits 7:0.
*/
package tfd_pkg;

  typedef enum logic [3:0] {
    FMT_UFLOAT10 = 4'h0,
    FMT_SHARED_EXPONENT_RGB = 4'h1,
    FMT_INTENSITY8 = 4'h2,
    FMT_LUMINANCE8_ALPHA8 = 4'h3,
    FMT_ONE_BIT_INTENSITY = 4'h4,
    FMT_MONO_BITMAP = 4'h5,
    FMT_INDEX_LO_ALPHA_HI_NIBBLE = 4'h6,
    FMT_ALPHA_LO_INDEX_HI_NIBBLE = 4'h7,
    FMT_INDEX_LO_ALPHA_HI_BYTE = 4'h8,
    FMT_ALPHA_LO_INDEX_HI_BYTE = 4'h9,
    FMT_BYTE_INDEX = 4'ha,
    FMT_TWO_BIT_INDEX = 4'hb,
    FMT_COMPRESSED_BLOCK = 4'hc
  } tfd_fmt_t;

  // Ten-bit float and shared exponent fields
  localparam int UF10_EXP_LO = 5;
  localparam logic [4:0] UF10_EXP_SPECIAL = 5'h1f;
  localparam logic [7:0] UF10_NORM_BIAS = 8'h6b;
  localparam logic [7:0] UF10_DENORM_EXP = 8'h6c;
  localparam logic [7:0] SE_BIAS = 8'h67;
  localparam int SE_EXP_LO = 27;
  localparam int SE_BLUE_LO = 18;
  localparam int SE_GREEN_LO = 9;
  localparam int SE_RED_LO = 0;

  // Single precision results and unorm one
  localparam logic [31:0] FP32_NAN = 32'h7fc00000;
  localparam logic [31:0] FP32_INF = 32'h7f800000;
  localparam logic [31:0] FP32_ONE = 32'h3f800000;
  localparam logic [7:0] UNORM_ONE = 8'hff;

  // Compressed block layout
  localparam logic [2:0] MODE_DIRECT = 3'h2;
  localparam logic [2:0] MODE_ALPHA = 3'h3;
  localparam int SPLIT_ALPHA_BIT = 124;
  localparam logic [6:0] TWO_C0_LSB = 7'h60;
  localparam logic [6:0] TWO_C1_LSB = 7'h6f;
  localparam logic [6:0] QUAD_C0_LSB = 7'h40;
  localparam logic [6:0] COLOR_BITS = 7'h0f;
  localparam logic [6:0] PAIR_STRIDE = 7'h1e;
  localparam logic [2:0] TWO_LAST_ENTRY = 3'h7;
  localparam logic [2:0] TWO_STEPS = 3'h6;
  localparam logic [2:0] SPLIT_STEPS_FULL = 3'h3;
  localparam logic [2:0] SPLIT_STEPS_HALF = 3'h2;

  localparam int PAL_ENTRIES = 256;

endpackage : tfd_pkg

//--- core/tfd_texel_decoder.sv
/*
  Texel format decoder: turns one raw texel word per cycle into four channel
  values, two cycles later. Holds its own texture palette, loaded by a write port.
  Assumes the fetch side delivers little-endian words and the filter accepts
  every result without stalling.
*/
`timescale 1ns/1ps
module tfd_texel_decoder (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input tfd_pkg::tfd_fmt_t fmt_i,
  input wire logic [127:0] word_i,
  input wire logic [4:0] texel_sel_i,
  input wire logic mono_filter_i,
  input wire logic as_dest_i,
  input wire logic pal_wr_i,
  input wire logic [7:0] pal_addr_i,
  input wire logic [31:0] pal_data_i,
  output logic valid_o,
  output logic err_o,
  output logic float_o,
  output logic [31:0] red_o,
  output logic [31:0] green_o,
  output logic [31:0] blue_o,
  output logic [31:0] alpha_o
);

  // ---------------------------------------------------------------------------
  // Arithmetic helpers
  // ---------------------------------------------------------------------------

  // Unsigned fixed value frac*2^(exp0-127) to single precision
  function automatic logic [31:0] fixed_to_fp32(input logic [8:0] frac,
                                                input logic [7:0] exp0);
    logic [3:0] p;
    logic [31:0] sh;
    logic [31:0] res;
    p = 4'h0;
    res = 32'h0;
    for (int i = 0; i < 9; i++)
      if (frac[i])
        p = 4'(i);
    sh = {frac, 23'h0} << (4'h8 - p);
    if (frac != 9'h0)
      res = {1'b0, 8'(exp0 + {4'h0, p}), sh[30:8]};
    return res;
  endfunction : fixed_to_fp32

  // Ten-bit unsigned float to single precision
  function automatic logic [31:0] uf10_to_fp32(input logic [9:0] w);
    logic [4:0] e;
    logic [4:0] f;
    logic [31:0] res;
    e = w[9:tfd_pkg::UF10_EXP_LO];
    f = w[tfd_pkg::UF10_EXP_LO-1:0];
    if (e == tfd_pkg::UF10_EXP_SPECIAL)
      res = (f != 5'h0) ? tfd_pkg::FP32_NAN : tfd_pkg::FP32_INF;
    else if (e == 5'h0)
      res = fixed_to_fp32({4'h0, f}, tfd_pkg::UF10_DENORM_EXP);
    else
      res = fixed_to_fp32({3'h0, 1'b1, f}, 8'(tfd_pkg::UF10_NORM_BIAS + {3'h0, e}));
    return res;
  endfunction : uf10_to_fp32

  // Five-bit channel to eight by copying its top bits below it
  function automatic logic [7:0] widen5(input logic [4:0] c);
    return {c, c[4:2]};
  endfunction : widen5

  function automatic logic [23:0] widen555(input logic [14:0] c);
    return {widen5(c[14:10]), widen5(c[9:5]), widen5(c[4:0])};
  endfunction : widen555

  // Rounded ((n-k)*a + k*b + n/2) / n for one channel
  function automatic logic [7:0] lerp8(input logic [7:0] a, input logic [7:0] b,
                                       input logic [2:0] k, input logic [2:0] n);
    logic [10:0] s;
    s = 11'(a) * 11'(3'(n - k)) + 11'(b) * 11'(k) + 11'(n >> 1);
    return 8'(s / 11'(n));
  endfunction : lerp8

  function automatic logic [23:0] lerp_rgb(input logic [23:0] a, input logic [23:0] b,
                                           input logic [2:0] k, input logic [2:0] n);
    return {lerp8(a[23:16], b[23:16], k, n), lerp8(a[15:8], b[15:8], k, n),
            lerp8(a[7:0], b[7:0], k, n)};
  endfunction : lerp_rgb

  // ---------------------------------------------------------------------------
  // Stage 0: legality and palette index
  // ---------------------------------------------------------------------------

  logic fmt_err;
  logic [7:0] pal_idx;

  // Refused requests still flow down the pipe so latency never varies
  always_comb
  begin
    fmt_err = 1'b0;
    if (mono_filter_i && fmt_i != tfd_pkg::FMT_MONO_BITMAP)
      fmt_err = 1'b1;
    if (as_dest_i && (fmt_i == tfd_pkg::FMT_INTENSITY8))
      fmt_err = 1'b1;
    if (as_dest_i && (fmt_i == tfd_pkg::FMT_LUMINANCE8_ALPHA8))
      fmt_err = 1'b1;
    if (fmt_i == tfd_pkg::FMT_COMPRESSED_BLOCK && word_i[127:125] == tfd_pkg::MODE_ALPHA)
      fmt_err = 1'b1;
    if (4'(fmt_i) > 4'(tfd_pkg::FMT_COMPRESSED_BLOCK))
      fmt_err = 1'b1;
  end

  // Index extraction; read one cycle ahead of the decode
  always_comb
  begin
    case (fmt_i)
      tfd_pkg::FMT_INDEX_LO_ALPHA_HI_NIBBLE: pal_idx = {4'h0, word_i[3:0]};
      tfd_pkg::FMT_ALPHA_LO_INDEX_HI_NIBBLE: pal_idx = {4'h0, word_i[7:4]};
      tfd_pkg::FMT_INDEX_LO_ALPHA_HI_BYTE: pal_idx = word_i[7:0];
      tfd_pkg::FMT_ALPHA_LO_INDEX_HI_BYTE: pal_idx = word_i[15:8];
      tfd_pkg::FMT_BYTE_INDEX: pal_idx = word_i[7:0];
      tfd_pkg::FMT_TWO_BIT_INDEX: pal_idx = {6'h0, word_i[1:0]};
      default: pal_idx = 8'h0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Palette store
  // ---------------------------------------------------------------------------

  logic [31:0] palette_mem [tfd_pkg::PAL_ENTRIES];
  logic [31:0] pal_q_r;

  // A write and a read of one entry in the same cycle return the old entry
  always_ff @(posedge clock_i)
  begin
    if (pal_wr_i)
      palette_mem[pal_addr_i] <= pal_data_i;
    pal_q_r <= palette_mem[pal_idx];
  end

  // ---------------------------------------------------------------------------
  // Stage 1 registers
  // ---------------------------------------------------------------------------

  logic s1_valid_r;
  logic s1_err_r;
  tfd_pkg::tfd_fmt_t s1_fmt_r;
  logic [127:0] s1_word_r;
  logic [4:0] s1_sel_r;

  // Valid clears on reset; the data path registers below are reset as well
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      s1_valid_r <= 1'b0;
    else
      s1_valid_r <= valid_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s1_err_r <= 1'b0;
      s1_fmt_r <= tfd_pkg::FMT_UFLOAT10;
      s1_word_r <= 128'h0;
      s1_sel_r <= 5'h0;
    end
    else
    begin
      s1_err_r <= fmt_err;
      s1_fmt_r <= fmt_i;
      s1_word_r <= word_i;
      s1_sel_r <= texel_sel_i;
    end
  end

  // ---------------------------------------------------------------------------
  // Compressed block decode
  // ---------------------------------------------------------------------------

  logic [2:0] sel3;
  logic [1:0] sel2;
  logic [23:0] two_c0;
  logic [23:0] two_c1;
  logic [23:0] quad_c;
  logic [6:0] pair_lsb;
  logic [23:0] pair_a;
  logic [23:0] pair_b;
  logic [23:0] cmp_rgb;
  logic [7:0] cmp_alpha;

  assign sel3 = 3'(s1_word_r >> ({2'h0, s1_sel_r} * 7'h03));
  assign sel2 = 2'(s1_word_r >> {1'b0, s1_sel_r, 1'b0});
  assign two_c0 = widen555(15'(s1_word_r >> tfd_pkg::TWO_C0_LSB));
  assign two_c1 = widen555(15'(s1_word_r >> tfd_pkg::TWO_C1_LSB));
  assign quad_c = widen555(15'(s1_word_r >>
                  7'(tfd_pkg::QUAD_C0_LSB + {5'h0, sel2} * tfd_pkg::COLOR_BITS)));
  // Upper half of the block uses the second colour pair
  assign pair_lsb = 7'(tfd_pkg::QUAD_C0_LSB + (s1_sel_r[4] ? tfd_pkg::PAIR_STRIDE : 7'h0));
  assign pair_a = widen555(15'(s1_word_r >> pair_lsb));
  assign pair_b = widen555(15'(s1_word_r >> 7'(pair_lsb + tfd_pkg::COLOR_BITS)));

  // Mode bits 127:125 choose the table
  always_comb
  begin
    cmp_rgb = 24'h0;
    cmp_alpha = tfd_pkg::UNORM_ONE;
    if (s1_word_r[127])
    begin
      if (!s1_word_r[tfd_pkg::SPLIT_ALPHA_BIT])
        cmp_rgb = lerp_rgb(pair_a, pair_b, {1'b0, sel2}, tfd_pkg::SPLIT_STEPS_FULL);
      else if (sel2 == 2'h3)
        cmp_alpha = 8'h0;
      else
        cmp_rgb = lerp_rgb(pair_a, pair_b, {1'b0, sel2}, tfd_pkg::SPLIT_STEPS_HALF);
    end
    else if (s1_word_r[127:125] == tfd_pkg::MODE_DIRECT)
      cmp_rgb = quad_c;
    else if (!s1_word_r[126])
    begin
      if (sel3 == tfd_pkg::TWO_LAST_ENTRY)
        cmp_alpha = 8'h0;
      else
        cmp_rgb = lerp_rgb(two_c0, two_c1, sel3, tfd_pkg::TWO_STEPS);
    end
  end

  // ---------------------------------------------------------------------------
  // Stage 2 channel assembly
  // ---------------------------------------------------------------------------

  logic [31:0] red_nxt;
  logic [31:0] green_nxt;
  logic [31:0] blue_nxt;
  logic [31:0] alpha_nxt;
  logic float_nxt;
  logic mono_bit;
  logic [4:0] se_exp;

  assign mono_bit = s1_word_r[s1_sel_r[2:0]];
  assign se_exp = s1_word_r[31:tfd_pkg::SE_EXP_LO];

  // Unorm channels carry the code in the low byte; its value is code/255
  always_comb
  begin
    red_nxt = 32'h0;
    green_nxt = 32'h0;
    blue_nxt = 32'h0;
    alpha_nxt = {24'h0, tfd_pkg::UNORM_ONE};
    float_nxt = 1'b0;
    case (s1_fmt_r)
      tfd_pkg::FMT_UFLOAT10:
      begin
        red_nxt = uf10_to_fp32(s1_word_r[9:0]);
        alpha_nxt = tfd_pkg::FP32_ONE;
        float_nxt = 1'b1;
      end
      tfd_pkg::FMT_SHARED_EXPONENT_RGB:
      begin
        red_nxt = fixed_to_fp32(s1_word_r[tfd_pkg::SE_RED_LO +: 9],
                                8'(tfd_pkg::SE_BIAS + {3'h0, se_exp}));
        green_nxt = fixed_to_fp32(s1_word_r[tfd_pkg::SE_GREEN_LO +: 9],
                                  8'(tfd_pkg::SE_BIAS + {3'h0, se_exp}));
        blue_nxt = fixed_to_fp32(s1_word_r[tfd_pkg::SE_BLUE_LO +: 9],
                                 8'(tfd_pkg::SE_BIAS + {3'h0, se_exp}));
        alpha_nxt = tfd_pkg::FP32_ONE;
        float_nxt = 1'b1;
      end
      tfd_pkg::FMT_INTENSITY8:
      begin
        red_nxt = {24'h0, s1_word_r[7:0]};
        green_nxt = {24'h0, s1_word_r[7:0]};
        blue_nxt = {24'h0, s1_word_r[7:0]};
        alpha_nxt = {24'h0, s1_word_r[7:0]};
      end
      tfd_pkg::FMT_LUMINANCE8_ALPHA8:
      begin
        red_nxt = {24'h0, s1_word_r[7:0]};
        green_nxt = {24'h0, s1_word_r[7:0]};
        blue_nxt = {24'h0, s1_word_r[7:0]};
        alpha_nxt = {24'h0, s1_word_r[15:8]};
      end
      tfd_pkg::FMT_ONE_BIT_INTENSITY, tfd_pkg::FMT_MONO_BITMAP:
      begin
        red_nxt = {24'h0, {8{mono_bit}}};
        green_nxt = {24'h0, {8{mono_bit}}};
        blue_nxt = {24'h0, {8{mono_bit}}};
        alpha_nxt = {24'h0, {8{mono_bit}}};
      end
      tfd_pkg::FMT_INDEX_LO_ALPHA_HI_NIBBLE, tfd_pkg::FMT_ALPHA_LO_INDEX_HI_NIBBLE,
      tfd_pkg::FMT_INDEX_LO_ALPHA_HI_BYTE, tfd_pkg::FMT_ALPHA_LO_INDEX_HI_BYTE:
      begin
        red_nxt = {24'h0, pal_q_r[23:16]};
        green_nxt = {24'h0, pal_q_r[15:8]};
        blue_nxt = {24'h0, pal_q_r[7:0]};
        if (s1_fmt_r == tfd_pkg::FMT_INDEX_LO_ALPHA_HI_NIBBLE)
          alpha_nxt = {24'h0, s1_word_r[7:4], s1_word_r[7:4]};
        else if (s1_fmt_r == tfd_pkg::FMT_ALPHA_LO_INDEX_HI_NIBBLE)
          alpha_nxt = {24'h0, s1_word_r[3:0], s1_word_r[3:0]};
        else if (s1_fmt_r == tfd_pkg::FMT_INDEX_LO_ALPHA_HI_BYTE)
          alpha_nxt = {24'h0, s1_word_r[15:8]};
        else
          alpha_nxt = {24'h0, s1_word_r[7:0]};
      end
      tfd_pkg::FMT_BYTE_INDEX, tfd_pkg::FMT_TWO_BIT_INDEX:
      begin
        red_nxt = {24'h0, pal_q_r[23:16]};
        green_nxt = {24'h0, pal_q_r[15:8]};
        blue_nxt = {24'h0, pal_q_r[7:0]};
        alpha_nxt = {24'h0, pal_q_r[31:24]};
      end
      tfd_pkg::FMT_COMPRESSED_BLOCK:
      begin
        red_nxt = {24'h0, cmp_rgb[23:16]};
        green_nxt = {24'h0, cmp_rgb[15:8]};
        blue_nxt = {24'h0, cmp_rgb[7:0]};
        alpha_nxt = {24'h0, cmp_alpha};
      end
      default:
        float_nxt = 1'b0;
    endcase
    // Refused words leave all channels at zero
    if (s1_err_r)
    begin
      red_nxt = 32'h0;
      green_nxt = 32'h0;
      blue_nxt = 32'h0;
      alpha_nxt = 32'h0;
      float_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------------------

  logic valid_r;
  logic err_r;
  logic float_r;
  logic [31:0] red_r;
  logic [31:0] green_r;
  logic [31:0] blue_r;
  logic [31:0] alpha_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      valid_r <= 1'b0;
      err_r <= 1'b0;
      float_r <= 1'b0;
      red_r <= 32'h0;
      green_r <= 32'h0;
      blue_r <= 32'h0;
      alpha_r <= 32'h0;
    end
    else
    begin
      valid_r <= s1_valid_r;
      err_r <= s1_valid_r & s1_err_r;
      float_r <= float_nxt;
      red_r <= red_nxt;
      green_r <= green_nxt;
      blue_r <= blue_nxt;
      alpha_r <= alpha_nxt;
    end
  end

  assign valid_o = valid_r;
  assign err_o = err_r;
  assign float_o = float_r;
  assign red_o = red_r;
  assign green_o = green_r;
  assign blue_o = blue_r;
  assign alpha_o = alpha_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic s1_ok;
  assign s1_ok = s1_valid_r && !s1_err_r;

  chk_fixed_latency: assert property (valid_i |-> ##2 valid_o)
    else $error("valid did not emerge two cycles later");
  chk_uf10_nan: assert property (s1_ok && s1_fmt_r == tfd_pkg::FMT_UFLOAT10 &&
    s1_word_r[9:5] == 5'h1f && s1_word_r[4:0] != 5'h0 |=> red_o == 32'h7fc00000)
    else $error("ten-bit NaN not produced");
  chk_uf10_inf: assert property (s1_ok && s1_fmt_r == tfd_pkg::FMT_UFLOAT10 &&
    s1_word_r[9:0] == 10'h3e0 |=> red_o == 32'h7f800000)
    else $error("ten-bit infinity not produced");
  chk_uf10_max: assert property (valid_i && !fmt_err && fmt_i == tfd_pkg::FMT_UFLOAT10 &&
    word_i[9:0] == 10'h3df |-> ##2 red_o == 32'h477c0000 && float_o)
    else $error("largest ten-bit float is not 64512");
  chk_shared_sign: assert property (s1_ok && s1_fmt_r == tfd_pkg::FMT_SHARED_EXPONENT_RGB
    |=> !red_o[31] && !green_o[31] && !blue_o[31] && red_o[30:23] != 8'hff)
    else $error("shared exponent gave sign or special value");
  chk_intensity_copy: assert property (s1_ok && s1_fmt_r == tfd_pkg::FMT_INTENSITY8
    |=> alpha_o == red_o && blue_o == red_o && red_o[7:0] == $past(s1_word_r[7:0]))
    else $error("intensity not copied to all channels");
  chk_mono_refuse: assert property (valid_i && mono_filter_i &&
    fmt_i != tfd_pkg::FMT_MONO_BITMAP |-> ##2 valid_o && err_o && alpha_o == 32'h0)
    else $error("mono filter accepted another format");
  chk_two_black: assert property (s1_ok && s1_fmt_r == tfd_pkg::FMT_COMPRESSED_BLOCK &&
    s1_word_r[127:126] == 2'h0 && sel3 == 3'h7 |=> alpha_o == 32'h0 && red_o == 32'h0)
    else $error("two-colour last entry not transparent black");
  chk_nibble_alpha: assert property (s1_ok &&
    s1_fmt_r == tfd_pkg::FMT_INDEX_LO_ALPHA_HI_NIBBLE |=>
    alpha_o[7:0] == {$past(s1_word_r[7:4]), $past(s1_word_r[7:4])})
    else $error("nibble alpha not duplicated");

endmodule : tfd_texel_decoder

//--- dv/tfd_fetch_model.sv
/*
  Fetch-side model: hands one raw texel word a cycle to the decoder.
  Assumes the bench raises go_i just after a clock edge, once per word.
*/
`timescale 1ns/1ps
module tfd_fetch_model (
  input wire logic go_i,
  input tfd_pkg::tfd_fmt_t fmt_i,
  input wire logic [127:0] word_i,
  output logic valid_o,
  output tfd_pkg::tfd_fmt_t fmt_o,
  output logic [127:0] word_o
);
  logic [127:0] last_r = '0;
  // Idle bus shows the inverse of the last word, so stale data never passes
  always_comb
  begin
    valid_o = go_i;
    fmt_o = fmt_i;
    word_o = go_i ? word_i : ~last_r;
  end
  // Remember what was last on the bus
  always @(word_i or go_i)
  begin
    if (go_i)
      last_r = word_i;
  end
endmodule : tfd_fetch_model

//--- dv/tfd_texel_decoder_bench.sv
/*
  Self-checking bench for the texel format decoder.
  Assumes a two-cycle result latency and a palette loaded before use.
*/
`timescale 1ns/1ps
module tfd_texel_decoder_bench;
  typedef logic [129:0] tfd_res_t;
  logic clock_i, rst_i, go, mono_filter_i, as_dest_i, pal_wr_i, valid_i, valid_o, err_o, float_o;
  logic [4:0] texel_sel_i;
  logic [7:0] pal_addr_i;
  logic [31:0] pal_data_i, red_o, green_o, blue_o, alpha_o, seed, pe;
  logic [127:0] word, word_i, w;
  logic [1:0] vp;
  // Empty-queue flag of the watcher; kept apart from the stimulus word
  logic qe;
  tfd_pkg::tfd_fmt_t fmt, fmt_i;
  tfd_res_t expq [$];
  int errors, n_tests, cyc;
  logic [9:0] fw [6] = '{10'h3e0, 10'h3e1, 10'h3df, 10'h001, 10'h000, 10'h1e0};
  logic [31:0] fe [6] = '{32'h7f800000, 32'h7fc00000, 32'h477c0000, 32'h36000000, 32'h0,
    32'h3f800000};
  tfd_fetch_model i_tfd_fetch_model (.go_i(go), .fmt_i(fmt), .word_i(word),
    .valid_o(valid_i), .fmt_o(fmt_i), .word_o(word_i));
  tfd_texel_decoder i_tfd_texel_decoder (.clock_i(clock_i), .rst_i(rst_i), .valid_i(valid_i),
    .fmt_i(fmt_i), .word_i(word_i), .texel_sel_i(texel_sel_i), .mono_filter_i(mono_filter_i),
    .as_dest_i(as_dest_i), .pal_wr_i(pal_wr_i), .pal_addr_i(pal_addr_i),
    .pal_data_i(pal_data_i), .valid_o(valid_o), .err_o(err_o), .float_o(float_o),
    .red_o(red_o), .green_o(green_o), .blue_o(blue_o), .alpha_o(alpha_o));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic tfd_res_t un(input logic [31:0] c);
    return {2'b00, 24'h0, c[23:16], 24'h0, c[15:8], 24'h0, c[7:0], 24'h0, c[31:24]};
  endfunction : un
  // Five-bit channel widened by its own top bits
  function automatic logic [23:0] col(input logic [127:0] x, input int lsb);
    logic [14:0] c;
    c = x[lsb +: 15];
    return {c[14:10], c[14:12], c[9:5], c[9:7], c[4:0], c[4:2]};
  endfunction : col
  function automatic tfd_res_t two(input logic [127:0] x, input int k);
    logic [23:0] a, b, v;
    a = col(x, 96);
    b = col(x, 111);
    for (int j = 0; j < 3; j++)
      v[j*8 +: 8] = 8'(((6 - k) * a[j*8 +: 8] + k * b[j*8 +: 8] + 3) / 6);
    return (k == 7) ? '0 : un({8'hff, v});
  endfunction : two
  // One word on the fetch bus; stays up for back-to-back use
  task automatic send(input logic [3:0] f, input logic [127:0] x, input int s,
    input logic m, input logic d, input tfd_res_t e);
    fmt = tfd_pkg::tfd_fmt_t'(f);
    word = x;
    texel_sel_i = 5'(s);
    mono_filter_i = m;
    as_dest_i = d;
    go = 1'b1;
    expq.push_back(e);
    @(posedge clock_i);
    #1;
  endtask : send
  task automatic idle(input string s);
    go = 1'b0;
    pal_wr_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    $display("test %s done", s);
  endtask : idle
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Clock, timeout and result watcher
  // ----------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Pipeline of taken words, so a late or missing result shows at once
  always @(posedge clock_i)
  begin
    vp <= rst_i ? 2'b00 : {vp[0], valid_i};
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      complete_run();
    end
  end
  always @(negedge clock_i)
  begin
    if (valid_o !== vp[1])
    begin
      errors++;
      $display("[FAIL] %0t valid %h expected %h", $time, valid_o, vp[1]);
    end
    if (valid_o === 1'b1)
    begin
      n_tests++;
      qe = (expq.size() == 0);
      if (qe || {err_o, float_o, red_o, green_o, blue_o, alpha_o} !== expq[0])
      begin
        errors++;
        $display("[FAIL] %0t got %h expected %h", $time,
          {err_o, float_o, red_o, green_o, blue_o, alpha_o}, qe ? '0 : expq[0]);
      end
      if (!qe)
        void'(expq.pop_front());
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {go, mono_filter_i, as_dest_i, pal_wr_i, texel_sel_i, pal_addr_i, pal_data_i} = '0;
    {word, w, qe, errors, n_tests} = '0;
    fmt = tfd_pkg::FMT_UFLOAT10;
    seed = 32'd88062;
    rst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 6; i++)
      send(0, {118'h0, fw[i]}, 0, 0, 0,
        {2'b01, fe[i], 64'h0, 32'h3f800000});
    send(1, 128'h7ffc0100, 0, 0, 0,
      {2'b01, 32'h3f000000, 32'h0, 32'h3f7f8000, 32'h3f800000});
    idle("float");
    send(2, 128'h5a, 0, 0, 0, un(32'h5a5a5a5a));
    send(3, 128'h3c77, 0, 0, 0, un(32'h3c777777));
    // Each byte of the expectation is 0 or 1, then scaled to 0 or ff
    for (int i = 0; i < 16; i++)
      send(4 + i / 8, 128'ha5, i % 8, i / 8, 0,
        un({4{7'h0, 1'(8'ha5 >> (i % 8))}}) * 8'hff);
    idle("replicate");
    send(2, 128'h5a, 0, 1, 0, {1'b1, 129'h0});
    send(2, 128'h5a, 0, 0, 1, {1'b1, 129'h0});
    send(3, 128'h5a, 0, 0, 1, {1'b1, 129'h0});
    send(4'hd, 128'h5a, 0, 0, 0, {1'b1, 129'h0});
    send(4'hc, {3'b011, 125'h0}, 0, 0, 0, {1'b1, 129'h0});
    idle("refuse");
    pe = rnd();
    for (int i = 0; i < 2; i++)
    begin
      pal_wr_i = 1'b1;
      pal_addr_i = i ? 8'h5a : 8'h03;
      pal_data_i = i ? pe : 32'h80112233;
      @(posedge clock_i);
      #1;
    end
    pal_wr_i = 1'b0;
    send(6, 128'hc3, 0, 0, 0, un(32'hcc112233));
    send(7, 128'h3c, 0, 0, 0, un(32'hcc112233));
    send(8, 128'h9e03, 0, 0, 0, un(32'h9e112233));
    send(9, 128'h039e, 0, 0, 0, un(32'h9e112233));
    send(4'ha, 128'h5a, 0, 0, 0, un(pe));
    send(4'hb, 128'hfff, 0, 0, 0, un(32'h80112233));
    idle("palette");
    w = {3'b000, rnd(), rnd(), rnd(), 29'h0} ^ {2'b00, 1'(rnd()), 125'h0};
    for (int k = 0; k < 8; k++)
    begin
      w[3*k +: 3] = 3'(k);
      w[3*(24+k) +: 3] = 3'(7 - k);
    end
    for (int k = 0; k < 8; k++)
    begin
      send(4'hc, w, k, 0, 0, two(w, k));
      send(4'hc, w, 24 + k, 0, 0, two(w, 7 - k));
    end
    w = {3'b010, rnd(), rnd(), 61'h0};
    for (int t = 0; t < 4; t++)
    begin
      w[2*t +: 2] = 2'(t);
      w[2*(28+t) +: 2] = 2'(3 - t);
    end
    for (int t = 0; t < 4; t++)
    begin
      send(4'hc, w, t, 0, 0, un({8'hff, col(w, 64 + 15 * t)}));
      send(4'hc, w, 28 + t, 0, 0, un({8'hff, col(w, 109 - 15 * t)}));
    end
    w = {4'b1001, rnd(), rnd(), 60'h0};
    w[3:0] = 4'b1000;
    w[37:32] = 6'b111000;
    send(4'hc, w, 0, 0, 0, un({8'hff, col(w, 64)}));
    send(4'hc, w, 1, 0, 0, un({8'hff, col(w, 79)}));
    send(4'hc, w, 16, 0, 0, un({8'hff, col(w, 94)}));
    send(4'hc, w, 17, 0, 0, un({8'hff, col(w, 109)}));
    send(4'hc, w, 18, 0, 0, '0);
    // Four-step table: select 3 lands exactly on the pair's second colour
    w[124] = 1'b0;
    send(4'hc, w, 18, 0, 0, un({8'hff, col(w, 109)}));
    idle("compressed");
    send(2, 128'h5a, 0, 0, 0, '0);
    go = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    expq.delete();
    idle("reset");
    complete_run();
  end
endmodule : tfd_texel_decoder_bench
